// File: verilog/lcdc_map.svh
`ifndef LCDC_MAP_SVH
`define LCDC_MAP_SVH
// Contract
// - Upper nibble 1111 enters test; resets leave it
// - 01xxxxxx loads six-bit display start line
// - 1011xxxx loads four-bit page address
// - 0001/0000 load column high/low nibble
// - Data write stores byte at page/column
// - Data read returns byte at page/column
// - 1010000x selects segment order normal/reversed
// - 1010011x selects normal or inverted image
// - 1010010x selects normal display/all pixels on
// - 1010001x selects drive bias ratio
// - Read-modify-write: write increments, read holds column
// - 11101110 ends it, restoring saved column
// - 1100xxxx: bit 3 picks common scan direction
// - 00101xxx sets three supply enable bits
// - 00100xxx sets divider resistor ratio
// - After 10000001 next byte loads contrast
// - 1010110x indicator off/on, on takes blink byte
// - 1010100x power save; 11100001 restores state
// - 0011xxxx loads reversal count; 11100100 disables
// - Oscillator start, internal reset, no-operation
// - Display memory never cleared, undefined after reset
// - Indicator-on locks decoder until blink byte
// - Reversal codes 1..15 mean 2..16 lines

// Pin vector layout after synchronising
`define LCDC_PIN_HWRES 11
`define LCDC_PIN_A0 10
`define LCDC_PIN_RD 9
`define LCDC_PIN_WR 8
`define LCDC_PIN_IDLE 12'hB00

// Opcode masks and values
`define LCDC_M2 8'hC0
`define LCDC_M4 8'hF0
`define LCDC_M5 8'hF8
`define LCDC_M7 8'hFE
`define LCDC_OP_START 8'h40
`define LCDC_OP_TEST 8'hF0
`define LCDC_OP_PAGE 8'hB0
`define LCDC_OP_COLH 8'h10
`define LCDC_OP_COLL 8'h00
`define LCDC_OP_COM 8'hC0
`define LCDC_OP_NLINE 8'h30
`define LCDC_OP_PWR 8'h28
`define LCDC_OP_RATIO 8'h20
`define LCDC_OP_ADC 8'hA0
`define LCDC_OP_BIAS 8'hA2
`define LCDC_OP_ALLON 8'hA4
`define LCDC_OP_INV 8'hA6
`define LCDC_OP_PSAVE 8'hA8
`define LCDC_OP_IND 8'hAC
`define LCDC_OP_DISP 8'hAE
`define LCDC_OP_OSC 8'hAB
`define LCDC_OP_CONTRAST 8'h81
`define LCDC_OP_RMW 8'hE0
`define LCDC_OP_PSRST 8'hE1
`define LCDC_OP_RESET 8'hE2
`define LCDC_OP_NOP 8'hE3
`define LCDC_OP_NLOFF 8'hE4
`define LCDC_OP_END 8'hEE

// Field positions and reset values
`define LCDC_COMDIR_BIT 3
`define LCDC_RST_CONTRAST 6'h20
`define LCDC_RST_RATIO 3'h0
`define LCDC_RST_SUPPLY 3'h0
`endif

// File: verilog/lcdc_pkg.sv
package lcdc_pkg;
	typedef enum logic [1:0] {
		LCDC_SEQ_CMD,
		LCDC_SEQ_CONTRAST,
		LCDC_SEQ_IND
	} lcdc_seq_t;
	typedef logic [7:0] lcdc_byte_t;
endpackage : lcdc_pkg

// File: verilog/lcdc_buf.sv
`timescale 1ns/1ps
`default_nettype none

module lcdc_buf #(
	parameter int W = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] tail_q;
	logic tail_v_q;
	logic push;
	logic pop;

	// Two registered slots: head feeds the output, tail absorbs a stall
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			out_data <= '0;
			out_valid <= 1'b0;
			tail_q <= '0;
			tail_v_q <= 1'b0;
			in_ready <= 1'b1;
		end else begin
			if (pop) begin
				if (tail_v_q) begin
					out_data <= tail_q;
					tail_v_q <= 1'b0;
					in_ready <= 1'b1;
				end else begin
					out_valid <= push;
					if (push) begin
						out_data <= in_data;
					end
				end
			end else if (push) begin
				if (!out_valid) begin
					out_data <= in_data;
					out_valid <= 1'b1;
				end else begin
					tail_q <= in_data;
					tail_v_q <= 1'b1;
					in_ready <= 1'b0;
				end
			end
		end
	end
endmodule : lcdc_buf

`default_nettype wire

// File: verilog/lcdc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_map.svh"

module lcdc_top #(
	parameter int PAGE_W = 4
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic hw_reset_input_n,
	input wire logic cmd_data_select,
	input wire logic host_rd_n,
	input wire logic host_wr_n,
	input wire logic [7:0] host_data_i,
	output logic [7:0] host_data_o,
	output logic host_data_oe,
	output logic [7:0] rd_stream_data,
	output logic rd_stream_valid,
	input wire logic rd_stream_ready,
	output logic display_on,
	output logic [5:0] start_line,
	output logic [PAGE_W-1:0] page_addr,
	output logic [7:0] col_addr,
	output logic seg_reverse,
	output logic image_invert,
	output logic all_pixels_on,
	output logic bias_select,
	output logic com_reverse,
	output logic [2:0] supply_enable,
	output logic [2:0] divider_resistor_ratio,
	output logic [5:0] contrast,
	output logic indicator_on,
	output logic [1:0] indicator_blink,
	output logic power_save,
	output logic sleep_mode,
	output logic [3:0] nline_count,
	output logic nline_enable,
	output logic osc_running,
	output logic test_mode,
	output logic rmw_mode
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [11:0] pin_raw;
	logic [11:0] pin_s1_q;
	logic [11:0] pin_s2_q;
	logic [11:0] pin_s3_q;
	logic [11:0] pin_q;
	logic [1:0] strb_prev_q;

	assign pin_raw = {hw_reset_input_n, cmd_data_select, host_rd_n, host_wr_n, host_data_i};

	// A bit moves only once stages two and three agree
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin_s1_q <= `LCDC_PIN_IDLE;
			pin_s2_q <= `LCDC_PIN_IDLE;
			pin_s3_q <= `LCDC_PIN_IDLE;
			pin_q <= `LCDC_PIN_IDLE;
			strb_prev_q <= 2'h3;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
			strb_prev_q <= {pin_q[`LCDC_PIN_RD], pin_q[`LCDC_PIN_WR]};
		end
	end

	// ------------------------------------------------------------
	// Strobes and command decode
	// ------------------------------------------------------------
	lcdc_pkg::lcdc_seq_t seq_q;
	lcdc_pkg::lcdc_byte_t b;
	logic live;
	logic a0;
	logic wr_ev;
	logic rd_ev;
	logic wr_cmd;
	logic wr_dat;
	logic rd_dat;
	logic is_cmd;
	logic soft_clr;

	assign b = pin_q[7:0];
	assign live = pin_q[`LCDC_PIN_HWRES];
	assign a0 = pin_q[`LCDC_PIN_A0];
	// Write takes the byte on the rising edge of the write strobe
	assign wr_ev = live & pin_q[`LCDC_PIN_WR] & ~strb_prev_q[0];
	assign rd_ev = live & ~pin_q[`LCDC_PIN_RD] & strb_prev_q[1];
	assign wr_cmd = wr_ev & ~a0;
	assign wr_dat = wr_ev & a0;
	assign rd_dat = rd_ev & a0;
	assign is_cmd = wr_cmd & (seq_q == lcdc_pkg::LCDC_SEQ_CMD);

	logic c_start, c_test, c_page, c_colh, c_coll, c_com, c_nline, c_pwr;
	logic c_ratio, c_adc, c_bias, c_allon, c_inv, c_psave, c_ind, c_disp;
	logic c_osc, c_contrast, c_rmw, c_psrst, c_reset, c_nop, c_nloff, c_end;

	// Masked compares so invalid bits never steer the match
	assign c_start = is_cmd && (b & `LCDC_M2) == `LCDC_OP_START;
	assign c_test = is_cmd && (b & `LCDC_M4) == `LCDC_OP_TEST;
	assign c_page = is_cmd && (b & `LCDC_M4) == `LCDC_OP_PAGE;
	assign c_colh = is_cmd && (b & `LCDC_M4) == `LCDC_OP_COLH;
	assign c_coll = is_cmd && (b & `LCDC_M4) == `LCDC_OP_COLL;
	assign c_com = is_cmd && (b & `LCDC_M4) == `LCDC_OP_COM;
	assign c_nline = is_cmd && (b & `LCDC_M4) == `LCDC_OP_NLINE;
	assign c_pwr = is_cmd && (b & `LCDC_M5) == `LCDC_OP_PWR;
	assign c_ratio = is_cmd && (b & `LCDC_M5) == `LCDC_OP_RATIO;
	assign c_adc = is_cmd && (b & `LCDC_M7) == `LCDC_OP_ADC;
	assign c_bias = is_cmd && (b & `LCDC_M7) == `LCDC_OP_BIAS;
	assign c_allon = is_cmd && (b & `LCDC_M7) == `LCDC_OP_ALLON;
	assign c_inv = is_cmd && (b & `LCDC_M7) == `LCDC_OP_INV;
	assign c_psave = is_cmd && (b & `LCDC_M7) == `LCDC_OP_PSAVE;
	assign c_ind = is_cmd && (b & `LCDC_M7) == `LCDC_OP_IND;
	assign c_disp = is_cmd && (b & `LCDC_M7) == `LCDC_OP_DISP;
	assign c_osc = is_cmd && b == `LCDC_OP_OSC;
	assign c_contrast = is_cmd && b == `LCDC_OP_CONTRAST;
	assign c_rmw = is_cmd && b == `LCDC_OP_RMW;
	assign c_psrst = is_cmd && b == `LCDC_OP_PSRST;
	assign c_reset = is_cmd && b == `LCDC_OP_RESET;
	assign c_nop = is_cmd && b == `LCDC_OP_NOP;
	assign c_nloff = is_cmd && b == `LCDC_OP_NLOFF;
	assign c_end = is_cmd && b == `LCDC_OP_END;

	// Pin reset and reset command share one synchronous clear
	assign soft_clr = ~live | c_reset;

	// ------------------------------------------------------------
	// Two-byte sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			seq_q <= lcdc_pkg::LCDC_SEQ_CMD;
		end else if (soft_clr) begin
			seq_q <= lcdc_pkg::LCDC_SEQ_CMD;
		end else if (wr_cmd) begin
			unique case (seq_q)
				lcdc_pkg::LCDC_SEQ_CMD: begin
					if (c_contrast) begin
						seq_q <= lcdc_pkg::LCDC_SEQ_CONTRAST;
					end else if (c_ind && b[0]) begin
						seq_q <= lcdc_pkg::LCDC_SEQ_IND;
					end
				end
				lcdc_pkg::LCDC_SEQ_CONTRAST: seq_q <= lcdc_pkg::LCDC_SEQ_CMD;
				lcdc_pkg::LCDC_SEQ_IND: seq_q <= lcdc_pkg::LCDC_SEQ_CMD;
				default: seq_q <= lcdc_pkg::LCDC_SEQ_CMD;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Display and drive settings
	// ------------------------------------------------------------
	logic [2:0] saved_supply_q;
	logic saved_osc_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			display_on <= 1'b0;
			start_line <= 6'h00;
			seg_reverse <= 1'b0;
			image_invert <= 1'b0;
			all_pixels_on <= 1'b0;
			bias_select <= 1'b0;
			com_reverse <= 1'b0;
			divider_resistor_ratio <= `LCDC_RST_RATIO;
			contrast <= `LCDC_RST_CONTRAST;
			nline_count <= 4'h0;
			nline_enable <= 1'b0;
			test_mode <= 1'b0;
		end else if (soft_clr) begin
			display_on <= 1'b0;
			start_line <= 6'h00;
			seg_reverse <= 1'b0;
			image_invert <= 1'b0;
			all_pixels_on <= 1'b0;
			bias_select <= 1'b0;
			com_reverse <= 1'b0;
			divider_resistor_ratio <= `LCDC_RST_RATIO;
			contrast <= `LCDC_RST_CONTRAST;
			nline_count <= 4'h0;
			nline_enable <= 1'b0;
			test_mode <= 1'b0;
		end else begin
			if (c_test) test_mode <= 1'b1;
			if (c_nop) test_mode <= 1'b0;
			if (c_disp) display_on <= b[0];
			if (c_start) start_line <= b[5:0];
			if (c_adc) seg_reverse <= b[0];
			if (c_inv) image_invert <= b[0];
			if (c_allon) all_pixels_on <= b[0];
			// Meaning of the bit depends on the voltage variant
			if (c_bias) bias_select <= b[0];
			if (c_com) com_reverse <= b[`LCDC_COMDIR_BIT];
			if (c_ratio) divider_resistor_ratio <= b[2:0];
			if (wr_cmd && seq_q == lcdc_pkg::LCDC_SEQ_CONTRAST) begin
				contrast <= b[5:0];
			end
			if (c_nline) begin
				nline_count <= b[3:0];
				nline_enable <= b[3:0] != 4'h0;
			end
			if (c_nloff) nline_enable <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Supplies, oscillator, power save
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			supply_enable <= `LCDC_RST_SUPPLY;
			osc_running <= 1'b0;
			power_save <= 1'b0;
			sleep_mode <= 1'b0;
			saved_supply_q <= `LCDC_RST_SUPPLY;
			saved_osc_q <= 1'b0;
		end else if (soft_clr) begin
			supply_enable <= `LCDC_RST_SUPPLY;
			osc_running <= 1'b0;
			power_save <= 1'b0;
			sleep_mode <= 1'b0;
			saved_supply_q <= `LCDC_RST_SUPPLY;
			saved_osc_q <= 1'b0;
		end else if (c_psave) begin
			// Save only on first entry so a repeat keeps the real state
			if (!power_save) begin
				saved_supply_q <= supply_enable;
				saved_osc_q <= osc_running;
			end
			power_save <= 1'b1;
			sleep_mode <= b[0];
			supply_enable <= 3'h0;
			osc_running <= b[0] ? 1'b0 : (power_save ? saved_osc_q : osc_running);
		end else if (c_psrst) begin
			if (power_save) begin
				supply_enable <= saved_supply_q;
				osc_running <= saved_osc_q;
			end
			power_save <= 1'b0;
			sleep_mode <= 1'b0;
		end else begin
			// Settings made during power save land in the restore copy
			if (c_pwr) begin
				if (power_save) begin
					saved_supply_q <= b[2:0];
				end else begin
					supply_enable <= b[2:0];
				end
			end
			if (c_osc) begin
				if (power_save) begin
					saved_osc_q <= 1'b1;
				end else begin
					osc_running <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Static indicator
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			indicator_on <= 1'b0;
			indicator_blink <= 2'h0;
		end else if (soft_clr) begin
			indicator_on <= 1'b0;
			indicator_blink <= 2'h0;
		end else if (c_ind) begin
			indicator_on <= b[0];
		end else if (wr_cmd && seq_q == lcdc_pkg::LCDC_SEQ_IND) begin
			indicator_blink <= b[1:0];
		end
	end

	// ------------------------------------------------------------
	// Addressing and read-modify-write
	// ------------------------------------------------------------
	logic [7:0] col_save_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			page_addr <= '0;
			col_addr <= 8'h00;
			col_save_q <= 8'h00;
			rmw_mode <= 1'b0;
		end else if (soft_clr) begin
			page_addr <= '0;
			col_addr <= 8'h00;
			col_save_q <= 8'h00;
			rmw_mode <= 1'b0;
		end else begin
			if (c_page) page_addr <= b[PAGE_W-1:0];
			if (c_colh) col_addr[7:4] <= b[3:0];
			if (c_coll) col_addr[3:0] <= b[3:0];
			if (c_rmw && !rmw_mode) begin
				col_save_q <= col_addr;
				rmw_mode <= 1'b1;
			end
			if (c_end && rmw_mode) begin
				col_addr <= col_save_q;
				rmw_mode <= 1'b0;
			end
			// Reads advance the column only outside read-modify-write
			if (wr_dat || (rd_dat && !rmw_mode)) begin
				col_addr <= col_addr + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Display memory
	// ------------------------------------------------------------
	logic [7:0] mem_q [2**(PAGE_W+8)];

	// No reset: contents stay undefined until the host fills them
	always_ff @(posedge clock) begin
		if (wr_dat) begin
			mem_q[{page_addr, col_addr}] <= b;
		end
	end

	// ------------------------------------------------------------
	// Read return: pin driver and buffered stream
	// ------------------------------------------------------------
	logic [7:0] rd_word;
	logic [7:0] rd_hold_q;
	logic rd_pend_q;
	logic buf_ready;

	assign rd_word = a0 ? mem_q[{page_addr, col_addr}] : {1'b0, seg_reverse, ~display_on, 5'h00};

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			host_data_o <= 8'h00;
			host_data_oe <= 1'b0;
		end else if (rd_ev) begin
			host_data_o <= rd_word;
			host_data_oe <= 1'b1;
		end else if (pin_q[`LCDC_PIN_RD] || !live) begin
			host_data_oe <= 1'b0;
		end
	end

	// A word waits here while the buffer is full
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_hold_q <= 8'h00;
			rd_pend_q <= 1'b0;
		end else if (rd_ev) begin
			rd_hold_q <= rd_word;
			rd_pend_q <= 1'b1;
		end else if (buf_ready) begin
			rd_pend_q <= 1'b0;
		end
	end

	lcdc_buf #(
		.W(8)
	) u_buf (
		.clock(clock),
		.resetn(resetn),
		.in_valid(rd_pend_q),
		.in_ready(buf_ready),
		.in_data(rd_hold_q),
		.out_valid(rd_stream_valid),
		.out_ready(rd_stream_ready),
		.out_data(rd_stream_data)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_contrast_arm;
		is_cmd && b == `LCDC_OP_CONTRAST;
	endsequence
	// Parameter byte arrives whenever the host gets to it, not at a fixed gap
	sequence s_contrast_param;
		seq_q == lcdc_pkg::LCDC_SEQ_CONTRAST && wr_cmd && live;
	endsequence

	property p_contrast_arm;
		s_contrast_arm |=> seq_q == lcdc_pkg::LCDC_SEQ_CONTRAST;
	endproperty
	a_contrast_arm: assert property (p_contrast_arm) else $error("contrast wait not armed");

	property p_contrast;
		s_contrast_param |=>
			contrast == $past(b[5:0]) && seq_q == lcdc_pkg::LCDC_SEQ_CMD;
	endproperty
	a_contrast: assert property (p_contrast) else $error("contrast not loaded");

	property p_start;
		c_start |=> start_line == $past(b[5:0]);
	endproperty
	a_start: assert property (p_start) else $error("start line wrong");

	property p_page;
		c_page |=> page_addr == $past(b[PAGE_W-1:0]) && $stable(col_addr);
	endproperty
	a_page: assert property (p_page) else $error("page wrong");

	property p_test_exit;
		test_mode && (c_nop || !live) |=> !test_mode;
	endproperty
	a_test_exit: assert property (p_test_exit) else $error("test not left");

	property p_ind_lock;
		seq_q == lcdc_pkg::LCDC_SEQ_IND && wr_cmd && live |=>
			indicator_blink == $past(b[1:0]) && $stable(start_line) && $stable(page_addr);
	endproperty
	a_ind_lock: assert property (p_ind_lock) else $error("indicator lock broken");

	property p_rmw_wr;
		rmw_mode && wr_dat |=> col_addr == $past(col_addr) + 8'h01;
	endproperty
	a_rmw_wr: assert property (p_rmw_wr) else $error("rmw write step");

	property p_rmw_rd;
		rmw_mode && rd_dat && !wr_cmd |=> $stable(col_addr);
	endproperty
	a_rmw_rd: assert property (p_rmw_rd) else $error("rmw read moved column");

	property p_rmw_end;
		rmw_mode && c_end |=> col_addr == $past(col_save_q) && !rmw_mode;
	endproperty
	a_rmw_end: assert property (p_rmw_end) else $error("rmw end restore");

	property p_nline_off;
		c_nloff |=> !nline_enable && $stable(nline_count);
	endproperty
	a_nline_off: assert property (p_nline_off) else $error("reversal disable");

	property p_read_drive;
		rd_ev |=> host_data_oe && host_data_o == $past(rd_word) ##1 rd_pend_q || rd_stream_valid;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not returned");
endmodule : lcdc_top

`default_nettype wire

// File: testbench/lcdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host processor on the parallel pins
// ----------------------------------------
module lcdc_host_model (
	input wire logic clock,
	output logic cmd_data_select,
	output logic host_rd_n,
	output logic host_wr_n,
	output logic [7:0] host_data_i,
	input wire logic [7:0] host_data_o,
	input wire logic host_data_oe
);
	initial begin
		cmd_data_select = 1'b0;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		host_data_i = 8'h5A;
	end

	// Each strobe phase lasts over 5 clocks so the pin synchroniser sees it
	task wr(input logic sel, input logic [7:0] d);
		@(posedge clock);
		#1;
		cmd_data_select = sel;
		host_data_i = d;
		host_wr_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 host_wr_n = 1'b1;
		repeat (6) @(posedge clock);
		// Released bus shows the inverse, never a stale copy
		#1 host_data_i = ~d;
	endtask : wr

	task rd(input logic sel, output logic [7:0] d, output logic oe);
		@(posedge clock);
		#1;
		cmd_data_select = sel;
		host_rd_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 d = host_data_o;
		oe = host_data_oe;
		host_rd_n = 1'b1;
		repeat (7) @(posedge clock);
	endtask : rd
endmodule : lcdc_host_model

`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic hw_n = 1'b1;
	logic rd_ready = 1'b1;
	logic cds, rdn, wrn, hoe, svalid, disp, segment_outputs, inv, allon, bias, comr;
	logic ind, psave, sleep, nlen, osc, test, rmw;
	logic [7:0] hd_i, hd_o, sdata, col, rv;
	logic [5:0] start, contrast;
	logic [3:0] page, nlc;
	logic [2:0] sup, ratio;
	logic [1:0] blink;
	logic [5:0] e;
	logic roe;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] bc [12] = '{8'hA1, 8'hA0, 8'hA7, 8'hA6, 8'hA5, 8'hA4,
		8'hA3, 8'hA2, 8'hCF, 8'hC7, 8'hAF, 8'hAE};

	lcdc_host_model host_u (.clock(clock), .cmd_data_select(cds), .host_rd_n(rdn),
		.host_wr_n(wrn), .host_data_i(hd_i), .host_data_o(hd_o), .host_data_oe(hoe));

	lcdc_top dut_u (.clock(clock), .resetn(resetn), .hw_reset_input_n(hw_n),
		.cmd_data_select(cds), .host_rd_n(rdn), .host_wr_n(wrn), .host_data_i(hd_i),
		.host_data_o(hd_o), .host_data_oe(hoe), .rd_stream_data(sdata),
		.rd_stream_valid(svalid), .rd_stream_ready(rd_ready), .display_on(disp),
		.start_line(start), .page_addr(page), .col_addr(col), .seg_reverse(segment_outputs),
		.image_invert(inv), .all_pixels_on(allon), .bias_select(bias), .com_reverse(comr),
		.supply_enable(sup), .divider_resistor_ratio(ratio), .contrast(contrast),
		.indicator_on(ind), .indicator_blink(blink), .power_save(psave), .sleep_mode(sleep),
		.nline_count(nlc), .nline_enable(nlen), .osc_running(osc), .test_mode(test),
		.rmw_mode(rmw));

	// ----------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------
	always #2.5 clock = ~clock;

	always @(posedge clock) begin
		cycles++;
		if (cycles == 10000) begin
			failures++;
			final_report();
		end
	end

	task final_report();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task cmd(input logic [7:0] c);
		host_u.wr(1'b0, c);
	endtask : cmd

	task done(input string n);
		$display("test %s done", n);
	endtask : done

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clock);
		#1 resetn = 1'b1;
		repeat (2) @(posedge clock);
		cmd(8'h7F);
		chk(start, 6'h3F);
		cmd(8'hB5);
		chk(page, 4'h5);
		cmd(8'h1A);
		cmd(8'h0C);
		chk(col, 8'hAC);
		done("addressing");
		e = 6'h00;
		// Low bits of the scan command are don't-care
		for (int i = 0; i < 12; i++) begin
			cmd(bc[i]);
			e[5 - i / 2] = ~i[0];
			chk({segment_outputs, inv, allon, bias, comr, disp}, e);
		end
		done("mode bits");
		cmd(8'h2F);
		chk(sup, 3'h7);
		cmd(8'h25);
		chk(ratio, 3'h5);
		cmd(8'h81);
		cmd(8'hD5);
		chk(contrast, 6'h15);
		cmd(8'hAD);
		cmd(8'hA1);
		chk({ind, blink, segment_outputs}, 4'hA);
		cmd(8'hAC);
		chk(ind, 1'b0);
		done("parameters");
		cmd(8'hAB);
		chk(osc, 1'b1);
		cmd(8'hA9);
		chk({psave, sleep, sup, osc}, 6'h30);
		cmd(8'hE1);
		chk({psave, sleep, sup, osc}, 6'h0F);
		cmd(8'hA8);
		chk({psave, sleep, osc}, 3'h5);
		cmd(8'hE1);
		cmd(8'h3F);
		chk({nlen, nlc}, 5'h1F);
		cmd(8'hE4);
		chk({nlen, nlc}, 5'h0F);
		cmd(8'h31);
		chk({nlen, nlc}, 5'h11);
		cmd(8'h30);
		chk(nlen, 1'b0);
		done("power and reversal");
		// Memory written before any read of it
		cmd(8'hB2);
		cmd(8'h11);
		cmd(8'h00);
		host_u.wr(1'b1, 8'h55);
		host_u.wr(1'b1, 8'hAA);
		cmd(8'h11);
		cmd(8'h00);
		rd_ready = 1'b0;
		host_u.rd(1'b1, rv, roe);
		chk({roe, rv}, 9'h155);
		host_u.rd(1'b1, rv, roe);
		chk(rv, 8'hAA);
		chk(col, 8'h12);
		chk({svalid, sdata}, 9'h155);
		@(posedge clock);
		#1 rd_ready = 1'b1;
		@(posedge clock);
		#1 rd_ready = 1'b0;
		@(posedge clock);
		#1 chk({svalid, sdata}, 9'h1AA);
		rd_ready = 1'b1;
		done("memory and stream");
		cmd(8'h11);
		cmd(8'h00);
		cmd(8'hE0);
		chk(rmw, 1'b1);
		host_u.rd(1'b1, rv, roe);
		chk({rv, col}, 16'h5510);
		host_u.wr(1'b1, 8'h66);
		chk(col, 8'h11);
		host_u.wr(1'b1, 8'h77);
		chk(col, 8'h12);
		cmd(8'hEE);
		chk({rmw, col}, 9'h010);
		host_u.rd(1'b1, rv, roe);
		chk(rv, 8'h66);
		done("read modify write");
		// Test command issued on purpose here only
		cmd(8'hF5);
		chk(test, 1'b1);
		cmd(8'hE3);
		chk(test, 1'b0);
		cmd(8'hA1);
		cmd(8'hF8);
		cmd(8'hE2);
		chk({test, segment_outputs, contrast}, 8'h20);
		cmd(8'hFF);
		cmd(8'h81);
		cmd(8'h3F);
		chk({test, contrast}, 7'h7F);
		@(posedge clock);
		#1 hw_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 hw_n = 1'b1;
		repeat (6) @(posedge clock);
		chk({test, contrast}, 7'h20);
		host_u.rd(1'b0, rv, roe);
		chk({roe, rv}, 9'h120);
		done("test mode and resets");
		final_report();
	end
endmodule : testbench

`default_nettype wire
